// ### dbcf_pkg.sv
package dbcf_pkg;

  localparam int DBCF_BANKS = 8;
  localparam int DBCF_BA_W = 3;
  localparam int DBCF_ADDR_W = 14;
  localparam int DBCF_COL_W = 10;
  localparam int DBCF_AUTOCLOSE_BIT = 10;
  localparam int DBCF_CLK_MHZ = 25;
  localparam int DBCF_CLK_PS = 40000;

  // Minimum times in picoseconds; mode set in clocks
  localparam int DBCF_ROW_CLOSE_PS = 15000;
  localparam int DBCF_ROW_TO_COL_PS = 15000;
  localparam int DBCF_WRITE_REC_PS = 15000;
  localparam int DBCF_ROW_CYCLE_PS = 60000;
  localparam int DBCF_MODE_SET_CK = 2;

  function automatic int dbcf_cycles(input int ps);
    int c;
    c = (ps + DBCF_CLK_PS - 1) / DBCF_CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction : dbcf_cycles

  localparam int DBCF_ROW_CLOSE_CYC = dbcf_cycles(DBCF_ROW_CLOSE_PS);
  localparam int DBCF_ROW_TO_COL_CYC = dbcf_cycles(DBCF_ROW_TO_COL_PS);
  localparam int DBCF_WRITE_REC_CYC = dbcf_cycles(DBCF_WRITE_REC_PS);
  localparam int DBCF_ROW_CYCLE_CYC = dbcf_cycles(DBCF_ROW_CYCLE_PS);
  localparam int DBCF_MODE_SET_CYC = DBCF_MODE_SET_CK;
  localparam int DBCF_TMR_W = 4;
  localparam int DBCF_BURST_DEF = 4;

  typedef enum logic [3:0] {
    DBCF_CMD_DESELECT = 4'h0,
    DBCF_CMD_NOP = 4'h1,
    DBCF_CMD_READ = 4'h2,
    DBCF_CMD_STORE = 4'h3,
    DBCF_CMD_ROW_OPEN = 4'h4,
    DBCF_CMD_CLOSE = 4'h5,
    DBCF_CMD_REFRESH = 4'h6,
    DBCF_CMD_MODE_SET = 4'h7
  } dbcf_cmd_t;

  typedef enum logic [3:0] {
    DBCF_ST_IDLE = 4'h0,
    DBCF_ST_ACTIVATING = 4'h1,
    DBCF_ST_ACTIVE = 4'h3,
    DBCF_ST_READ = 4'h2,
    DBCF_ST_READ_AC = 4'h6,
    DBCF_ST_WRITE = 4'h7,
    DBCF_ST_WRITE_AC = 4'h5,
    DBCF_ST_WREC = 4'h4,
    DBCF_ST_WREC_AC = 4'hC,
    DBCF_ST_PRECHARGE = 4'hD,
    DBCF_ST_REFRESH = 4'hF,
    DBCF_ST_SELF_REFRESH = 4'hE,
    DBCF_ST_MODE_SET = 4'hA
  } dbcf_state_t;

  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [DBCF_BA_W-1:0] ba;
    logic [DBCF_ADDR_W-1:0] addr;
  } dbcf_pins_t;

  typedef struct packed {
    logic valid;
    dbcf_cmd_t cmd;
    logic prev_cke;
    logic cke;
    logic [DBCF_BA_W-1:0] ba;
    logic [DBCF_ADDR_W-1:0] addr;
  } dbcf_dec_t;

endpackage : dbcf_pkg

// ### dbcf_decode.sv
`timescale 1ns/1ps
module dbcf_decode
  import dbcf_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input dbcf_pins_t pins,
  output dbcf_dec_t dec
);

  dbcf_pins_t meta_q;
  dbcf_pins_t sync_q;
  logic cke_prev_q;

  function automatic dbcf_cmd_t dbcf_decode_cmd(input dbcf_pins_t p);
    if (p.cs_n) begin
      return DBCF_CMD_DESELECT;
    end
    unique case ({p.ras_n, p.cas_n, p.we_n})
      3'b111: return DBCF_CMD_NOP;
      3'b101: return DBCF_CMD_READ;
      3'b100: return DBCF_CMD_STORE;
      3'b011: return DBCF_CMD_ROW_OPEN;
      3'b010: return DBCF_CMD_CLOSE;
      3'b001: return DBCF_CMD_REFRESH;
      3'b000: return DBCF_CMD_MODE_SET;
      default: return DBCF_CMD_NOP;
    endcase
  endfunction : dbcf_decode_cmd

  // Pins come from outside the clock domain
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
      sync_q <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
    end else begin
      meta_q <= pins;
      sync_q <= meta_q;
    end
  end

  // Command taken from one rising-edge sample of the strobes; clock enable from that sample and the one before
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cke_prev_q <= 1'b0;
      dec <= '0;
    end else begin
      cke_prev_q <= sync_q.cke;
      dec.valid <= cke_prev_q;
      dec.cmd <= dbcf_decode_cmd(sync_q);
      dec.prev_cke <= cke_prev_q;
      dec.cke <= sync_q.cke;
      dec.ba <= sync_q.ba;
      dec.addr <= sync_q.addr;
    end
  end

endmodule : dbcf_decode

// ### dbcf_bank.sv
`timescale 1ns/1ps
module dbcf_bank
  import dbcf_pkg::*;
#(
  parameter int BANK_ID = 0
) (
  input wire logic clk,
  input wire logic reset_n,
  input dbcf_dec_t dec,
  input wire logic [3:0] burst_len,
  output dbcf_state_t state_q,
  output logic illegal_q,
  output logic [DBCF_COL_W-1:0] column_q
);

  logic [DBCF_TMR_W-1:0] tmr_q;
  logic [3:0] beat_q;
  logic hit;
  logic all_sel;
  logic ac;
  logic cmd_live;
  logic illegal_d;
  dbcf_state_t state_d;
  logic [DBCF_TMR_W-1:0] tmr_d;

  initial begin
    if (BANK_ID < 0 || BANK_ID >= DBCF_BANKS) $error("bad bank id");
  end

  assign cmd_live = dec.valid && dec.cke;
  assign hit = (dec.ba == DBCF_BA_W'(BANK_ID));
  assign all_sel = dec.addr[DBCF_AUTOCLOSE_BIT];
  assign ac = dec.addr[DBCF_AUTOCLOSE_BIT];

  function automatic logic [DBCF_TMR_W-1:0] dbcf_tmr(input int c);
    return DBCF_TMR_W'(c - 1);
  endfunction : dbcf_tmr

  // Beat count is in clocks, two clocks per four data beats; the load is odd at length 8
  // Zero is the burst's own end, so a new column there is no cut
  function automatic logic dbcf_cut_bad(input logic [3:0] bl, input logic [3:0] beat);
    return (beat != 4'h0) && (bl != 4'h8 || beat[0] != 1'b0);
  endfunction : dbcf_cut_bad

  always_comb begin
    state_d = state_q;
    tmr_d = (tmr_q != '0) ? tmr_q - 1'b1 : tmr_q;
    illegal_d = 1'b0;
    unique case (state_q)
      DBCF_ST_IDLE: begin
        if (dec.valid && dec.cmd == DBCF_CMD_REFRESH) begin
          // Self refresh when clock enable drops with it
          state_d = dec.cke ? DBCF_ST_REFRESH : DBCF_ST_SELF_REFRESH;
          tmr_d = dbcf_tmr(DBCF_ROW_CYCLE_CYC);
        end else if (cmd_live && dec.cmd == DBCF_CMD_MODE_SET) begin
          state_d = DBCF_ST_MODE_SET;
          tmr_d = dbcf_tmr(DBCF_MODE_SET_CYC);
        end else if (cmd_live && hit && dec.cmd == DBCF_CMD_ROW_OPEN) begin
          state_d = DBCF_ST_ACTIVATING;
          tmr_d = dbcf_tmr(DBCF_ROW_TO_COL_CYC);
        end else if (cmd_live && (hit || all_sel) && dec.cmd == DBCF_CMD_CLOSE) begin
          state_d = DBCF_ST_PRECHARGE;
          tmr_d = dbcf_tmr(DBCF_ROW_CLOSE_CYC);
        end else if (cmd_live && hit && (dec.cmd == DBCF_CMD_READ || dec.cmd == DBCF_CMD_STORE)) begin
          illegal_d = 1'b1;
        end
      end
      DBCF_ST_ACTIVATING: begin
        if (tmr_q == '0) begin
          state_d = DBCF_ST_ACTIVE;
        end
        if (cmd_live && (hit || dec.cmd >= DBCF_CMD_REFRESH) && dec.cmd > DBCF_CMD_NOP) begin
          illegal_d = 1'b1;
        end
      end
      DBCF_ST_ACTIVE, DBCF_ST_READ, DBCF_ST_WRITE: begin
        if (state_q != DBCF_ST_ACTIVE && beat_q == 4'h0) begin
          state_d = (state_q == DBCF_ST_WRITE) ? DBCF_ST_WREC : DBCF_ST_ACTIVE;
          tmr_d = dbcf_tmr(DBCF_WRITE_REC_CYC);
        end
        if (cmd_live && hit && dec.cmd == DBCF_CMD_READ) begin
          // Interrupt legal only at burst 8 on a 4-beat boundary
          if (state_q == DBCF_ST_WRITE || (state_q == DBCF_ST_READ && dbcf_cut_bad(burst_len, beat_q))) begin
            illegal_d = 1'b1;
          end else begin
            state_d = ac ? DBCF_ST_READ_AC : DBCF_ST_READ;
          end
        end else if (cmd_live && hit && dec.cmd == DBCF_CMD_STORE) begin
          if (state_q == DBCF_ST_READ || (state_q == DBCF_ST_WRITE && dbcf_cut_bad(burst_len, beat_q))) begin
            illegal_d = 1'b1;
          end else begin
            state_d = ac ? DBCF_ST_WRITE_AC : DBCF_ST_WRITE;
          end
        end else if (cmd_live && (hit || all_sel) && dec.cmd == DBCF_CMD_CLOSE) begin
          if (state_q == DBCF_ST_ACTIVE) begin
            state_d = DBCF_ST_PRECHARGE;
            tmr_d = dbcf_tmr(DBCF_ROW_CLOSE_CYC);
          end else begin
            illegal_d = hit;
          end
        end else if (cmd_live && dec.cmd >= DBCF_CMD_REFRESH) begin
          illegal_d = 1'b1;
        end else if (cmd_live && hit && dec.cmd == DBCF_CMD_ROW_OPEN) begin
          illegal_d = 1'b1;
        end
      end
      DBCF_ST_READ_AC, DBCF_ST_WRITE_AC: begin
        if (beat_q == 4'h0) begin
          state_d = (state_q == DBCF_ST_READ_AC) ? DBCF_ST_PRECHARGE : DBCF_ST_WREC_AC;
          tmr_d = dbcf_tmr((state_q == DBCF_ST_READ_AC) ? DBCF_ROW_CLOSE_CYC : DBCF_WRITE_REC_CYC);
        end
        if (cmd_live && (hit || dec.cmd >= DBCF_CMD_REFRESH) && dec.cmd > DBCF_CMD_NOP) begin
          illegal_d = 1'b1;
        end
      end
      DBCF_ST_WREC: begin
        if (cmd_live && hit && dec.cmd == DBCF_CMD_STORE) begin
          state_d = ac ? DBCF_ST_WRITE_AC : DBCF_ST_WRITE;
        end else begin
          if (tmr_q == '0) begin
            state_d = DBCF_ST_ACTIVE;
          end
          if (cmd_live && (hit || dec.cmd >= DBCF_CMD_REFRESH) && dec.cmd > DBCF_CMD_NOP) begin
            illegal_d = 1'b1;
          end
        end
      end
      DBCF_ST_WREC_AC: begin
        if (tmr_q == '0) begin
          // Device starts its own close
          state_d = DBCF_ST_PRECHARGE;
          tmr_d = dbcf_tmr(DBCF_ROW_CLOSE_CYC);
        end
        if (cmd_live && (hit || dec.cmd >= DBCF_CMD_REFRESH) && dec.cmd > DBCF_CMD_NOP) begin
          illegal_d = 1'b1;
        end
      end
      DBCF_ST_PRECHARGE: begin
        if (tmr_q == '0) begin
          state_d = DBCF_ST_IDLE;
        end
        if (cmd_live && (hit || dec.cmd >= DBCF_CMD_REFRESH) && dec.cmd > DBCF_CMD_NOP
            && dec.cmd != DBCF_CMD_CLOSE) begin
          illegal_d = 1'b1;
        end
      end
      DBCF_ST_REFRESH, DBCF_ST_MODE_SET: begin
        if (tmr_q == '0) begin
          state_d = DBCF_ST_IDLE;
        end
        if (cmd_live && dec.cmd > DBCF_CMD_NOP) begin
          illegal_d = 1'b1;
        end
      end
      DBCF_ST_SELF_REFRESH: begin
        // Exit when clock enable returns high
        if (dec.cke) begin
          state_d = DBCF_ST_IDLE;
        end
      end
      default: begin
        state_d = DBCF_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= DBCF_ST_IDLE;
      tmr_q <= '0;
      illegal_q <= 1'b0;
    end else begin
      state_q <= state_d;
      tmr_q <= tmr_d;
      illegal_q <= illegal_d;
    end
  end

  // Burst beat counter; two data beats per clock
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      beat_q <= '0;
      column_q <= '0;
    end else if (state_d != state_q || (state_q inside {DBCF_ST_READ, DBCF_ST_WRITE} && cmd_live && hit
                 && (dec.cmd == DBCF_CMD_READ || dec.cmd == DBCF_CMD_STORE) && !illegal_d)) begin
      if (state_d inside {DBCF_ST_READ, DBCF_ST_WRITE, DBCF_ST_READ_AC, DBCF_ST_WRITE_AC}) begin
        beat_q <= (burst_len >> 1) - 4'h1;
        column_q <= dec.addr[DBCF_COL_W-1:0];
      end
    end else if (beat_q != 4'h0) begin
      beat_q <= beat_q - 4'h1;
    end
  end

endmodule : dbcf_bank

// ### dbcf_top.sv
`timescale 1ns/1ps
// Operation
// - Commands decode from chip select, strobes, write enable and clock enable at edge.
// - Idle refresh command starts auto refresh, or self refresh with clock enable low.
// - Close command closes addressed bank if idle or active; all idle or active banks when select bit high.
// - Deselect or no-op lets a burst run to its programmed end.
// - During read with auto-close only deselect or no-op is legal.
// - After close, idle after row close time; only no-op or close meanwhile.
// - After row open, active after row-to-column delay; only no-op meanwhile.
// - Write recovery returns to active; new store allowed, others illegal.
// - Auto-close write recovery ends in the device's own close.
// - Auto refresh returns idle after row cycle time; only no-op meanwhile.
// - Mode set returns idle after mode-set delay; only no-op meanwhile.
module dbcf_top
  import dbcf_pkg::*;
#(
  parameter int BANKS = DBCF_BANKS
) (
  input wire logic clk,
  input wire logic reset_n,
  input dbcf_pins_t pins,
  input wire logic [3:0] burst_len,
  output dbcf_state_t [DBCF_BANKS-1:0] bank_state,
  output logic [DBCF_BANKS-1:0] bank_illegal,
  output logic [DBCF_BANKS-1:0] bank_reading,
  output logic [DBCF_BANKS-1:0] bank_writing,
  output logic all_idle,
  output logic [DBCF_BANKS*DBCF_COL_W-1:0] bank_column
);

  initial begin
    if (BANKS != DBCF_BANKS) $error("bank count fixed by package");
  end

  dbcf_dec_t dec;
  logic [3:0] bl_meta_q;
  logic [3:0] bl_q;
  logic [3:0] bl_use;
  logic [DBCF_BANKS-1:0] idle_vec;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bl_meta_q <= 4'h4;
      bl_q <= 4'h4;
    end else begin
      bl_meta_q <= burst_len;
      bl_q <= bl_meta_q;
    end
  end

  // Lengths other than 8 run as 4
  assign bl_use = (bl_q == 4'h8) ? 4'h8 : 4'h4;

  dbcf_decode u_decode (
    .clk(clk),
    .reset_n(reset_n),
    .pins(pins),
    .dec(dec)
  );

  ////////////////////////////////////////////////////////////////////////////
  for (genvar b = 0; b < DBCF_BANKS; b++) begin : g_bank
    dbcf_bank #(.BANK_ID(b)) u_bank (
      .clk(clk),
      .reset_n(reset_n),
      .dec(dec),
      .burst_len(bl_use),
      .state_q(bank_state[b]),
      .illegal_q(bank_illegal[b]),
      .column_q(bank_column[b*DBCF_COL_W +: DBCF_COL_W])
    );
    assign idle_vec[b] = (bank_state[b] == DBCF_ST_IDLE);
  end

  // Registered status views
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      all_idle <= 1'b1;
      bank_reading <= '0;
      bank_writing <= '0;
    end else begin
      all_idle <= &idle_vec;
      for (int i = 0; i < DBCF_BANKS; i++) begin
        bank_reading[i] <= bank_state[i] inside {DBCF_ST_READ, DBCF_ST_READ_AC};
        bank_writing[i] <= bank_state[i] inside {DBCF_ST_WRITE, DBCF_ST_WRITE_AC};
      end
    end
  end

endmodule : dbcf_top

// ### dbcf_props.sv
`timescale 1ns/1ps
module dbcf_props
  import dbcf_pkg::*;
#(
  parameter int BANKS = DBCF_BANKS
) (
  input wire logic clk,
  input wire logic reset_n,
  input dbcf_pins_t pins,
  input wire logic [3:0] burst_len,
  input dbcf_state_t [DBCF_BANKS-1:0] bank_state,
  input wire logic [DBCF_BANKS-1:0] bank_illegal,
  input wire logic [DBCF_BANKS-1:0] bank_reading,
  input wire logic [DBCF_BANKS-1:0] bank_writing,
  input wire logic all_idle,
  input wire logic [DBCF_BANKS*DBCF_COL_W-1:0] bank_column
);
  dbcf_state_t st;
  assign st = bank_state[0];
  logic idle_now;
  assign idle_now = (bank_state == {DBCF_BANKS{DBCF_ST_IDLE}});
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////
  act_done_a: assert property (st == DBCF_ST_ACTIVATING |=> st == DBCF_ST_ACTIVE)
    else $error("row open did not reach active");
  close_done_a: assert property (st == DBCF_ST_PRECHARGE |=> st == DBCF_ST_IDLE)
    else $error("close did not reach idle");
  ref_done_a: assert property (st == DBCF_ST_REFRESH && $past(st) != DBCF_ST_REFRESH
    |=> st == DBCF_ST_REFRESH ##1 st == DBCF_ST_IDLE) else $error("refresh length wrong");
  mode_done_a: assert property (st == DBCF_ST_MODE_SET && $past(st) != DBCF_ST_MODE_SET
    |=> st == DBCF_ST_MODE_SET ##1 st == DBCF_ST_IDLE) else $error("mode set length wrong");
  ref_entry_a: assert property (st == DBCF_ST_REFRESH && $past(st) != DBCF_ST_REFRESH
    |-> $past(st) == DBCF_ST_IDLE) else $error("refresh entered from non idle");
  wrec_done_a: assert property (st == DBCF_ST_WREC
    |=> st inside {DBCF_ST_ACTIVE, DBCF_ST_WRITE, DBCF_ST_WRITE_AC}) else $error("write recovery end wrong");
  wrec_close_a: assert property (st == DBCF_ST_WREC_AC |=> st == DBCF_ST_PRECHARGE)
    else $error("no own close after write recovery");
  readac_close_a: assert property (st == DBCF_ST_READ_AC |-> ##[1:4] st == DBCF_ST_PRECHARGE)
    else $error("read with auto close did not close");
  illegal_hold_a: assert property (bank_illegal[0] && $past(st) inside {DBCF_ST_IDLE, DBCF_ST_ACTIVE}
    |-> st == $past(st)) else $error("illegal command changed state");
  read_flag_a: assert property (bank_reading[0] |-> $past(st) inside {DBCF_ST_READ, DBCF_ST_READ_AC})
    else $error("reading flag without read state");
  idle_view_a: assert property (all_idle == $past(idle_now))
    else $error("all idle view wrong");
  ////////////////////////////////////////////////////////////////
  wrec_ac_c: cover property (st == DBCF_ST_WREC_AC);
  read_ac_c: cover property (st == DBCF_ST_READ_AC);
  self_ref_c: cover property (st == DBCF_ST_SELF_REFRESH);
endmodule : dbcf_props

bind dbcf_top dbcf_props #(.BANKS(BANKS)) i_dbcf_props (.clk(clk), .reset_n(reset_n), .pins(pins),
  .burst_len(burst_len), .bank_state(bank_state), .bank_illegal(bank_illegal), .bank_reading(bank_reading),
  .bank_writing(bank_writing), .all_idle(all_idle), .bank_column(bank_column));

// ### dbcf_ctrl_model.sv
`timescale 1ns/1ps
module dbcf_ctrl_model
  import dbcf_pkg::*;
(
  input dbcf_cmd_t cmd,
  input wire logic cke,
  input wire logic [DBCF_BA_W-1:0] ba,
  input wire logic [DBCF_ADDR_W-1:0] addr,
  output dbcf_pins_t pins
);
  // Caller also sends refresh and mode set while a bank is open
  always_comb begin
    pins.cke = cke;
    pins.ba = ba;
    pins.addr = addr;
    pins.cs_n = 1'b0;
    {pins.ras_n, pins.cas_n, pins.we_n} = 3'h7;
    case (cmd)
      DBCF_CMD_DESELECT: pins.cs_n = 1'b1;
      DBCF_CMD_READ: {pins.ras_n, pins.cas_n, pins.we_n} = 3'h5;
      DBCF_CMD_STORE: {pins.ras_n, pins.cas_n, pins.we_n} = 3'h4;
      DBCF_CMD_ROW_OPEN: {pins.ras_n, pins.cas_n, pins.we_n} = 3'h3;
      DBCF_CMD_CLOSE: {pins.ras_n, pins.cas_n, pins.we_n} = 3'h2;
      DBCF_CMD_REFRESH: {pins.ras_n, pins.cas_n, pins.we_n} = 3'h1;
      DBCF_CMD_MODE_SET: {pins.ras_n, pins.cas_n, pins.we_n} = 3'h0;
      default: ;
    endcase
    // Address is meaningless here, so never show a stale value
    if (cmd == DBCF_CMD_DESELECT || cmd == DBCF_CMD_NOP) begin
      pins.addr = ~addr;
    end
  end
endmodule : dbcf_ctrl_model

// ### dram_bank_command_fsm_tb_top.sv
`timescale 1ns/1ps
module dram_bank_command_fsm_tb_top;
  import dbcf_pkg::*;
  typedef struct packed {
    dbcf_cmd_t cmd;
    logic cke;
    logic [DBCF_BA_W-1:0] ba;
    logic [DBCF_ADDR_W-1:0] addr;
    dbcf_state_t st;
    logic [2:0] flags;
  } dbcf_row_t;
  logic clk, reset_n, cke, sel_ill, sel_rd, sel_wr, all_idle;
  logic [3:0] burst_len;
  logic [DBCF_BA_W-1:0] ba;
  logic [DBCF_ADDR_W-1:0] addr;
  dbcf_cmd_t cmd;
  dbcf_pins_t pins;
  dbcf_state_t [DBCF_BANKS-1:0] bank_state;
  logic [DBCF_BANKS-1:0] bank_illegal, bank_reading, bank_writing;
  logic [DBCF_BANKS*DBCF_COL_W-1:0] bank_column;
  int miscompares, checks;
  dbcf_row_t rows[23];

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  dbcf_ctrl_model i_dbcf_ctrl_model (.cmd(cmd), .cke(cke), .ba(ba), .addr(addr), .pins(pins));
  dbcf_top i_dbcf_top (.clk(clk), .reset_n(reset_n), .pins(pins), .burst_len(burst_len),
    .bank_state(bank_state), .bank_illegal(bank_illegal), .bank_reading(bank_reading),
    .bank_writing(bank_writing), .all_idle(all_idle), .bank_column(bank_column));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One command cycle, then n quiet cycles gathering the bank's flags
  task automatic issue(input dbcf_cmd_t c, input logic k, input logic [2:0] b, input logic [13:0] a, input int n);
    @(negedge clk);
    cmd = c;
    cke = k;
    ba = b;
    addr = a;
    {sel_ill, sel_rd, sel_wr} = 3'h0;
    repeat (n) begin
      @(negedge clk);
      cmd = DBCF_CMD_NOP;
      sel_ill |= bank_illegal[b];
      sel_rd |= bank_reading[b];
      sel_wr |= bank_writing[b];
    end
  endtask : issue

  task automatic close_out;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////
  initial begin
    miscompares = 0;
    checks = 0;
    reset_n = 1'b0;
    cmd = DBCF_CMD_NOP;
    cke = 1'b1;
    ba = 3'h0;
    addr = 14'h0000;
    burst_len = 4'h4;
    {sel_ill, sel_rd, sel_wr} = 3'h0;
    rows = '{
      '{DBCF_CMD_MODE_SET, 1'b1, 3'h0, 14'h0000, DBCF_ST_IDLE, 3'h0},
      '{DBCF_CMD_REFRESH, 1'b1, 3'h0, 14'h0000, DBCF_ST_IDLE, 3'h0},
      '{DBCF_CMD_ROW_OPEN, 1'b1, 3'h0, 14'h0123, DBCF_ST_ACTIVE, 3'h0},
      '{DBCF_CMD_ROW_OPEN, 1'b1, 3'h0, 14'h0000, DBCF_ST_ACTIVE, 3'h4},
      '{DBCF_CMD_READ, 1'b1, 3'h0, 14'h0012, DBCF_ST_ACTIVE, 3'h2},
      '{DBCF_CMD_STORE, 1'b1, 3'h0, 14'h0034, DBCF_ST_ACTIVE, 3'h1},
      '{DBCF_CMD_REFRESH, 1'b1, 3'h0, 14'h0000, DBCF_ST_ACTIVE, 3'h4},
      '{DBCF_CMD_MODE_SET, 1'b1, 3'h0, 14'h0000, DBCF_ST_ACTIVE, 3'h4},
      '{DBCF_CMD_CLOSE, 1'b1, 3'h0, 14'h0000, DBCF_ST_IDLE, 3'h0},
      '{DBCF_CMD_READ, 1'b1, 3'h0, 14'h0000, DBCF_ST_IDLE, 3'h4},
      '{DBCF_CMD_STORE, 1'b1, 3'h0, 14'h0000, DBCF_ST_IDLE, 3'h4},
      '{DBCF_CMD_CLOSE, 1'b1, 3'h0, 14'h0000, DBCF_ST_IDLE, 3'h0},
      '{DBCF_CMD_ROW_OPEN, 1'b1, 3'h0, 14'h0001, DBCF_ST_ACTIVE, 3'h0},
      '{DBCF_CMD_STORE, 1'b1, 3'h0, 14'h0400, DBCF_ST_IDLE, 3'h1},
      '{DBCF_CMD_ROW_OPEN, 1'b1, 3'h0, 14'h0002, DBCF_ST_ACTIVE, 3'h0},
      '{DBCF_CMD_READ, 1'b1, 3'h0, 14'h0405, DBCF_ST_IDLE, 3'h2},
      '{DBCF_CMD_ROW_OPEN, 1'b1, 3'h0, 14'h0003, DBCF_ST_ACTIVE, 3'h0},
      '{DBCF_CMD_ROW_OPEN, 1'b1, 3'h1, 14'h0004, DBCF_ST_ACTIVE, 3'h0},
      '{DBCF_CMD_CLOSE, 1'b1, 3'h1, 14'h0400, DBCF_ST_IDLE, 3'h0},
      '{DBCF_CMD_READ, 1'b1, 3'h0, 14'h0000, DBCF_ST_IDLE, 3'h4},
      '{DBCF_CMD_REFRESH, 1'b0, 3'h0, 14'h0000, DBCF_ST_SELF_REFRESH, 3'h0},
      '{DBCF_CMD_NOP, 1'b1, 3'h0, 14'h0000, DBCF_ST_IDLE, 3'h0},
      '{DBCF_CMD_DESELECT, 1'b1, 3'h0, 14'h0000, DBCF_ST_IDLE, 3'h0}
    };
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    foreach (rows[i]) begin
      issue(rows[i].cmd, rows[i].cke, rows[i].ba, rows[i].addr, 8);
      chk(16'(bank_state[rows[i].ba]), 16'(rows[i].st));
      chk(16'({sel_ill, sel_rd, sel_wr}), 16'(rows[i].flags));
      $display("row %0d done", i);
    end
    // Read lands while the row is still opening
    chk(16'(all_idle), 16'h0001);
    issue(DBCF_CMD_ROW_OPEN, 1'b1, 3'h2, 14'h0001, 0);
    issue(DBCF_CMD_READ, 1'b1, 3'h2, 14'h0005, 8);
    chk(16'(sel_ill), 16'h0001);
    chk(16'(bank_state[2]), 16'(DBCF_ST_ACTIVE));
    chk(16'(all_idle), 16'h0000);
    $display("opening test done");
    // Store lands inside a read burst
    issue(DBCF_CMD_READ, 1'b1, 3'h2, 14'h0006, 0);
    issue(DBCF_CMD_STORE, 1'b1, 3'h2, 14'h0007, 8);
    chk(16'(sel_ill), 16'h0001);
    // No cut at all at length 4
    issue(DBCF_CMD_READ, 1'b1, 3'h2, 14'h0009, 0);
    issue(DBCF_CMD_READ, 1'b1, 3'h2, 14'h000A, 8);
    chk(16'(sel_ill), 16'h0001);
    $display("burst store test done");
    // Length 8 read interrupted on a four-beat boundary
    burst_len = 4'h8;
    issue(DBCF_CMD_NOP, 1'b1, 3'h2, 14'h0000, 4);
    issue(DBCF_CMD_READ, 1'b1, 3'h2, 14'h0008, 1);
    issue(DBCF_CMD_READ, 1'b1, 3'h2, 14'h0010, 8);
    chk(16'(sel_ill), 16'h0000);
    chk(16'(bank_column[2*DBCF_COL_W +: DBCF_COL_W]), 16'h0010);
    chk(16'(bank_state[2]), 16'(DBCF_ST_ACTIVE));
    // Cut one clock in lands off the boundary
    issue(DBCF_CMD_READ, 1'b1, 3'h2, 14'h0011, 0);
    issue(DBCF_CMD_READ, 1'b1, 3'h2, 14'h0012, 8);
    chk(16'(sel_ill), 16'h0001);
    chk(16'(bank_column[2*DBCF_COL_W +: DBCF_COL_W]), 16'h0011);
    $display("interrupt test done");
    // Reset in mid-burst, then a first read to the idle bank
    issue(DBCF_CMD_READ, 1'b1, 3'h2, 14'h0020, 4);
    chk(16'(bank_state[2]), 16'(DBCF_ST_READ));
    chk(16'(all_idle), 16'h0000);
    reset_n = 1'b0;
    @(negedge clk);
    chk(16'(bank_state[2]), 16'(DBCF_ST_IDLE));
    chk(16'(all_idle), 16'h0001);
    reset_n = 1'b1;
    issue(DBCF_CMD_READ, 1'b1, 3'h2, 14'h0021, 8);
    chk(16'(sel_ill), 16'h0001);
    chk(16'(bank_state[2]), 16'(DBCF_ST_IDLE));
    $display("reset test done");
    close_out();
  end
endmodule : dram_bank_command_fsm_tb_top
